// *** core/plc_cfg.svh ***
// Offsets, field positions, reset value and timing counts of the loop control.
`ifndef PLC_CFG_SVH
`define PLC_CFG_SVH

`define PLC_ADDR_W          4
`define PLC_OFF_LOOP_CTL    4'h0
`define PLC_OFF_STATUS      4'h1
`define PLC_BIT_CME         7
`define PLC_BIT_PON         6
`define PLC_BIT_SBW         5
`define PLC_BIT_WFS         4
`define PLC_BIT_RSVD        3
`define PLC_BIT_TPS         2
`define PLC_BIT_WPS         1
`define PLC_BIT_LME         0
`define PLC_RESET_VAL       8'hf1
`define PLC_LOSS_TIME_NS    1600
`define PLC_CLK_PERIOD_NS   50
`define PLC_LOSS_CYCLES     (`PLC_LOSS_TIME_NS / `PLC_CLK_PERIOD_NS)
`define PLC_NEAR_TOL        8'h04

`endif

// *** core/plc_pkg.sv ***
// Types shared by the loop control block and its helpers.
package plc_pkg;
   typedef enum logic [1:0] {
      PLC_RUN,
      PLC_PSEUDO_STOP,
      PLC_FULL_STOP
   } plc_power_t;
endpackage

// *** core/plc_mon_if.sv ***
// Carries the clock monitor control and verdict between block and monitor.
interface plc_mon_if;
   logic enable;
   logic edge_seen;
   logic clock_lost;
   modport ctrl (output enable, output edge_seen, input clock_lost);
   modport mon  (input enable, input edge_seen, output clock_lost);
endinterface

// *** core/plc_clock_monitor.sv ***
// Watchdog counter that flags a slow or stopped oscillator.
`include "plc_cfg.svh"
module plc_clock_monitor #(
   parameter int LOSS_CYCLES = `PLC_LOSS_CYCLES
) (
   input  wire logic clock_i,
   input  wire logic reset_n_i,
   plc_mon_if.mon    mon
);
   logic [15:0] gap_q;

   // Count bus cycles since the last oscillator edge; too long means lost.
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         gap_q <= 16'h0000;
      end else if (!mon.enable || mon.edge_seen) begin
         gap_q <= 16'h0000;
      end else if (gap_q != LOSS_CYCLES[15:0]) begin
         gap_q <= gap_q + 16'h0001;
      end
   end

   assign mon.clock_lost = mon.enable && (gap_q == LOSS_CYCLES[15:0]);
endmodule

// *** core/plc_divider.sv ***
// Free-running divider that can run, freeze or clear, for tick and watchdog.
module plc_divider #(
   parameter int WIDTH = 16
) (
   input  wire logic             clock_i,
   input  wire logic             reset_n_i,
   input  wire logic             run_i,
   input  wire logic             clear_i,
   output logic      [WIDTH-1:0] count_o
);
   // Clear wins over run; a frozen divider simply keeps its count.
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         count_o <= '0;
      end else if (clear_i) begin
         count_o <= '0;
      end else if (run_i) begin
         count_o <= count_o + {{(WIDTH-1){1'b0}}, 1'b1};
      end
   end
endmodule

// *** core/plc_loop_control.sv ***
// Loop control register with clock monitor, limp fallback and stop gating.
//
// Decided for this implementation: the address map and the address-and-strobe port.
`include "plc_cfg.svh"

// Summary of operation
// - Monitor enable frozen while limp active.
// - Enabled monitor catches slow or stopped oscillator.
// - Full stop disables the clock monitor.
// - Power-on bit switches loop; auto locks.
// - Power-on writes ignored while loop clock selected.
// - Limp forces loop on; read shows latch.
// - Self bandwidth picks filter from frequency error.
// - Off-in-wait holds self bandwidth set.
// - Manual mode: wide filter bit picks bandwidth.
// - Tick bit lets timer run in pseudo-stop.
// - Frozen tick dividers keep count, not cleared.
// - Watchdog bit lets watchdog run in pseudo-stop.
// - Frozen watchdog dividers keep count, not cleared.
// - Limp enable write-once normal, free special.
// - Limp enable cannot clear while limp active.
// - Clock loss: reset if limp off, else limp.
// - Register resets to f1.
// - Pseudo-stop keeps oscillator; full stop disables.
module plc_loop_control
   import plc_pkg::*;
#(
   parameter int LOSS_CYCLES = `PLC_LOSS_CYCLES,
   parameter int DIV_WIDTH   = 16
) (
   input  wire logic                   clock_i,
   input  wire logic                   reset_n_i,
   input  wire logic [`PLC_ADDR_W-1:0] addr_i,
   input  wire logic [7:0]             wdata_i,
   input  wire logic                   write_i,
   input  wire logic                   read_i,
   output logic      [7:0]             rdata_o,
   input  wire logic                   special_mode_i,
   input  wire logic                   pll_clock_select_i,
   input  wire logic                   pll_off_in_wait_i,
   input  wire logic                   oscillator_run_in_stop_i,
   input  wire logic                   stop_req_i,
   input  wire logic                   wait_req_i,
   input  wire logic                   tick_stop_in_wait_i,
   input  wire logic                   watchdog_stop_in_wait_i,
   input  wire logic                   osc_edge_i,
   input  wire logic                   limp_exit_i,
   input  wire logic [7:0]             freq_error_i,
   output logic                        pll_enable_o,
   output logic                        high_bandwidth_o,
   output logic                        oscillator_enable_o,
   output logic                        clock_monitor_reset_o,
   output logic                        limp_mode_active_o,
   output logic [DIV_WIDTH-1:0]        tick_count_o,
   output logic [DIV_WIDTH-1:0]        watchdog_count_o
);
   // Register bits, limp bookkeeping, read staging and divider controls.
   logic        clock_monitor_enable_q;
   logic        pll_power_on_q;
   logic        self_bandwidth_q;
   logic        wide_filter_select_q;
   logic        tick_in_pseudostop_q;
   logic        watchdog_in_pseudostop_q;
   logic        limp_mode_enable_q;
   logic        limp_written_q;
   logic        limp_mode_active_q;
   logic        high_bw_q;
   logic        cm_reset_q;
   logic [7:0]  rdata_q;
   logic        osc_s1_q;
   logic        osc_s2_q;
   logic        osc_s3_q;
   logic        ctl_wr;
   logic        clock_loss;
   logic        limp_entry;
   logic        tick_run;
   logic        tick_clear;
   logic        wdog_run;
   logic        wdog_clear;
   logic [7:0]  ctl_image;
   logic [7:0]  status_image;
   plc_power_t  power_state;
   plc_mon_if   mon_bus ();

   // Decode an address into a one-hot hit, shared by read and write paths.
   function automatic logic hit(input logic [`PLC_ADDR_W-1:0] a,
                                input logic [`PLC_ADDR_W-1:0] off);
      hit = (a == off);
   endfunction

   // Write strobe to the loop control word; other addresses take no writes.
   assign ctl_wr = write_i && hit(addr_i, `PLC_OFF_LOOP_CTL);

   // Power state from the stop request and the oscillator run-in-stop level.
   // Stop outranks wait, so a wait request inside stop changes nothing.
   always_comb begin
      if (!stop_req_i) begin
         power_state = PLC_RUN;
      end else if (oscillator_run_in_stop_i) begin
         power_state = PLC_PSEUDO_STOP;
      end else begin
         power_state = PLC_FULL_STOP;
      end
   end

   // The oscillator only stops in full stop.
   assign oscillator_enable_o = (power_state != PLC_FULL_STOP);

   // Clock monitor enable: writes refused while limp mode runs.
   // This keeps software from disarming the monitor that limp relies on.
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         clock_monitor_enable_q <= 1'b1;
      end else if (ctl_wr && !limp_mode_active_q) begin
         clock_monitor_enable_q <= wdata_i[`PLC_BIT_CME];
      end
   end

   // Power-on bit: frozen while the loop clock drives the system.
   // Turning the loop off under a running system clock would stall the bus.
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pll_power_on_q <= 1'b1;
      end else if (ctl_wr && !pll_clock_select_i) begin
         pll_power_on_q <= wdata_i[`PLC_BIT_PON];
      end
   end

   // Self bandwidth bit: forced high while off-in-wait is set.
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         self_bandwidth_q <= 1'b1;
      end else if (pll_off_in_wait_i) begin
         self_bandwidth_q <= 1'b1;
      end else if (ctl_wr) begin
         self_bandwidth_q <= wdata_i[`PLC_BIT_SBW];
      end
   end

   // Bits writable at any time: filter choice and pseudo-stop run bits.
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wide_filter_select_q     <= 1'b1;
         tick_in_pseudostop_q     <= 1'b0;
         watchdog_in_pseudostop_q <= 1'b0;
      end else if (ctl_wr) begin
         wide_filter_select_q     <= wdata_i[`PLC_BIT_WFS];
         tick_in_pseudostop_q     <= wdata_i[`PLC_BIT_TPS];
         watchdog_in_pseudostop_q <= wdata_i[`PLC_BIT_WPS];
      end
   end

   // Limp enable: one write after reset in normal modes, any in special.
   // Clearing is refused while limp mode is active, but the write still
   // counts as the single permitted one.
   // A clear that meets limp entry on the same edge is refused as well,
   // so limp mode never runs with its enable bit cleared.
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         limp_mode_enable_q <= 1'b1;
         limp_written_q     <= 1'b0;
      end else if (ctl_wr && (special_mode_i || !limp_written_q)) begin
         limp_written_q <= 1'b1;
         if (wdata_i[`PLC_BIT_LME]
             || !(limp_mode_active_q || limp_entry)) begin
            limp_mode_enable_q <= wdata_i[`PLC_BIT_LME];
         end
      end
   end

   // Monitor runs only when enabled and the oscillator is not switched off.
   assign mon_bus.enable = clock_monitor_enable_q
                           && (power_state != PLC_FULL_STOP);

   // The oscillator edge comes from another domain; two flops first.
   // The third flop feeds only the edge detector. A false edge right after
   // reset merely restarts the gap count, which is harmless.
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         osc_s1_q <= 1'b0;
         osc_s2_q <= 1'b0;
         osc_s3_q <= 1'b0;
      end else begin
         osc_s1_q <= osc_edge_i;
         osc_s2_q <= osc_s1_q;
         osc_s3_q <= osc_s2_q;
      end
   end

   assign mon_bus.edge_seen = osc_s2_q ^ osc_s3_q;

   // The loss limit counts bus cycles, so it must be retuned whenever the
   // bus clock rate changes; a slow oscillator near the limit may slip by.
   plc_clock_monitor #(
      .LOSS_CYCLES (LOSS_CYCLES)
   ) u_monitor (
      .clock_i   (clock_i),
      .reset_n_i (reset_n_i),
      .mon       (mon_bus)
   );

   assign clock_loss = mon_bus.clock_lost;

   // Loss with limp enabled enters limp mode on this very edge.
   assign limp_entry = clock_loss && limp_mode_enable_q;

   // Clock loss enters limp mode when enabled; set wins over exit.
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         limp_mode_active_q <= 1'b0;
      end else if (limp_entry) begin
         limp_mode_active_q <= 1'b1;
      end else if (limp_exit_i) begin
         limp_mode_active_q <= 1'b0;
      end
   end

   // Clock loss with limp disabled requests a monitor reset pulse.
   // It stays high while the loss lasts, so the reset logic sees a level.
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cm_reset_q <= 1'b0;
      end else begin
         cm_reset_q <= clock_loss && !limp_mode_enable_q;
      end
   end

   // Bandwidth: automatic from frequency error, else the filter bit.
   // Registered, so the filter choice cannot glitch within a cycle.
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         high_bw_q <= 1'b1;
      end else if (self_bandwidth_q) begin
         high_bw_q <= (freq_error_i > `PLC_NEAR_TOL);
      end else begin
         high_bw_q <= wide_filter_select_q;
      end
   end

   // Limp mode overrides a cleared power-on bit: the fallback clock needs
   // the loop alive, while software still reads back its own value.
   assign pll_enable_o = pll_power_on_q || limp_mode_active_q;
   assign high_bandwidth_o      = high_bw_q;
   assign clock_monitor_reset_o = cm_reset_q;
   assign limp_mode_active_o    = limp_mode_active_q;

   // Divider controls. Wait clears a divider only when its stop-in-wait
   // input is set and otherwise lets it count on, as in run. Pseudo-stop
   // never clears: it runs or freezes, so the count survives the nap.
   assign tick_run   = (power_state == PLC_RUN)
                       || (power_state == PLC_PSEUDO_STOP
                           && tick_in_pseudostop_q);
   assign tick_clear = wait_req_i && tick_stop_in_wait_i
                       && (power_state == PLC_RUN);
   assign wdog_run   = (power_state == PLC_RUN)
                       || (power_state == PLC_PSEUDO_STOP
                           && watchdog_in_pseudostop_q);
   assign wdog_clear = wait_req_i && watchdog_stop_in_wait_i
                       && (power_state == PLC_RUN);

   // Tick and watchdog dividers: pseudo-stop freezes unless the divider's run bit is set, wait may clear.
   plc_divider #(
      .WIDTH (DIV_WIDTH)
   ) u_tick (
      .clock_i   (clock_i),
      .reset_n_i (reset_n_i),
      .run_i     (tick_run),
      .clear_i   (tick_clear),
      .count_o   (tick_count_o)
   );

   plc_divider #(
      .WIDTH (DIV_WIDTH)
   ) u_watchdog (
      .clock_i   (clock_i),
      .reset_n_i (reset_n_i),
      .run_i     (wdog_run),
      .clear_i   (wdog_clear),
      .count_o   (watchdog_count_o)
   );

   // Register images as software sees them; the power-on bit shows the
   // latched value even while limp mode holds the loop on.
   assign ctl_image    = {clock_monitor_enable_q, pll_power_on_q,
                          self_bandwidth_q, wide_filter_select_q,
                          1'b0, tick_in_pseudostop_q,
                          watchdog_in_pseudostop_q, limp_mode_enable_q};
   // Status: bit one says the monitor is armed, bit zero limp mode.
   assign status_image = {6'h00, mon_bus.enable, limp_mode_active_q};

   // Read data registered one cycle after the strobe; bit three reads zero.
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rdata_q <= 8'h00;
      end else if (read_i && hit(addr_i, `PLC_OFF_LOOP_CTL)) begin
         rdata_q <= ctl_image;
      end else if (read_i && hit(addr_i, `PLC_OFF_STATUS)) begin
         rdata_q <= status_image;
      end else begin
         rdata_q <= 8'h00;
      end
   end

   assign rdata_o = rdata_q;
endmodule

// *** tb/plc_loop_control_props.sv ***
// Concurrent checks on the loop control block's ports.
module plc_loop_control_props #(
   parameter int DIV_WIDTH = 16
) (
   input wire logic                 clock_i,
   input wire logic                 reset_n_i,
   input wire logic                 read_i,
   input wire logic                 stop_req_i,
   input wire logic                 wait_req_i,
   input wire logic                 oscillator_run_in_stop_i,
   input wire logic                 tick_stop_in_wait_i,
   input wire logic                 watchdog_stop_in_wait_i,
   input wire logic [7:0]           rdata_o,
   input wire logic                 pll_enable_o,
   input wire logic                 oscillator_enable_o,
   input wire logic                 clock_monitor_reset_o,
   input wire logic                 limp_mode_active_o,
   input wire logic [DIV_WIDTH-1:0] tick_count_o,
   input wire logic [DIV_WIDTH-1:0] watchdog_count_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!reset_n_i);
   // Full stop is the only state that turns the oscillator off.
   wire full_stop = stop_req_i && !oscillator_run_in_stop_i;
   a_rdata_idle: assert property (!$past(read_i) |-> rdata_o == 8'h00)
      else $error("read data not idle");
   a_limp_forces_loop: assert property (
      limp_mode_active_o |-> pll_enable_o)
      else $error("loop off in limp mode");
   a_osc_enable_stop: assert property (
      oscillator_enable_o == !full_stop)
      else $error("oscillator enable wrong");
   a_loss_reset_limp: assert property (
      clock_monitor_reset_o |-> !limp_mode_active_o)
      else $error("monitor reset while limp");
   a_full_stop_blind: assert property (
      full_stop [*4] |-> !$rose(limp_mode_active_o)
                         && !$rose(clock_monitor_reset_o))
      else $error("loss seen in full stop");
   a_tick_kept_stop: assert property (
      stop_req_i && $past(stop_req_i)
      |-> tick_count_o == $past(tick_count_o)
          || tick_count_o == DIV_WIDTH'($past(tick_count_o) + 1))
      else $error("tick count lost in stop");
   a_wdog_kept_stop: assert property (
      stop_req_i && $past(stop_req_i)
      |-> watchdog_count_o == $past(watchdog_count_o)
          || watchdog_count_o == DIV_WIDTH'($past(watchdog_count_o) + 1))
      else $error("watchdog count lost in stop");
   a_tick_wait_clear: assert property (
      wait_req_i && !stop_req_i && tick_stop_in_wait_i
      |=> tick_count_o == '0)
      else $error("tick not cleared in wait");
   a_wdog_wait_clear: assert property (
      wait_req_i && !stop_req_i && watchdog_stop_in_wait_i
      |=> watchdog_count_o == '0)
      else $error("watchdog not cleared in wait");
   c_monitor_reset: cover property ($rose(clock_monitor_reset_o));
   c_limp_entry: cover property ($rose(limp_mode_active_o));
   c_full_stop: cover property (full_stop [*4]);
endmodule

bind plc_loop_control plc_loop_control_props #(.DIV_WIDTH(DIV_WIDTH))
   i_plc_loop_control_props (.clock_i(clock_i), .reset_n_i(reset_n_i),
   .read_i(read_i), .stop_req_i(stop_req_i), .wait_req_i(wait_req_i),
   .oscillator_run_in_stop_i(oscillator_run_in_stop_i),
   .tick_stop_in_wait_i(tick_stop_in_wait_i),
   .watchdog_stop_in_wait_i(watchdog_stop_in_wait_i), .rdata_o(rdata_o),
   .pll_enable_o(pll_enable_o), .oscillator_enable_o(oscillator_enable_o),
   .clock_monitor_reset_o(clock_monitor_reset_o),
   .limp_mode_active_o(limp_mode_active_o), .tick_count_o(tick_count_o),
   .watchdog_count_o(watchdog_count_o));

// *** tb/plc_loop_control_tb.sv ***
// Register and mode sequences for the loop control block.
`include "plc_cfg.svh"
module plc_loop_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int LOSS = 8;
   logic clk = 0, rst_n = 0, wr_s = 0, rd_s = 0, spec = 0, sel = 0, ow = 0;
   logic ris = 0, stp = 0, wt = 0, tsw = 0, wsw = 0, osc = 0, lx = 0;
   logic osc_run = 1;
   logic [3:0]  addr = '0;
   logic [7:0]  wd = '0, fe = '0, rdata, t0;
   logic        pon, hbw, osce, cmr, limp;
   logic [15:0] tick, wdog, w0;
   int          bad_count = 0, comparisons = 0;
   plc_loop_control #(.LOSS_CYCLES(LOSS)) i_plc_loop_control (
      .clock_i(clk), .reset_n_i(rst_n), .addr_i(addr), .wdata_i(wd),
      .write_i(wr_s), .read_i(rd_s), .rdata_o(rdata), .special_mode_i(spec),
      .pll_clock_select_i(sel), .pll_off_in_wait_i(ow),
      .oscillator_run_in_stop_i(ris), .stop_req_i(stp), .wait_req_i(wt),
      .tick_stop_in_wait_i(tsw), .watchdog_stop_in_wait_i(wsw),
      .osc_edge_i(osc), .limp_exit_i(lx), .freq_error_i(fe),
      .pll_enable_o(pon), .high_bandwidth_o(hbw), .oscillator_enable_o(osce),
      .clock_monitor_reset_o(cmr), .limp_mode_active_o(limp),
      .tick_count_o(tick), .watchdog_count_o(wdog));
   // Bus clock, 50 ns period.
   initial begin
      forever #25 clk = ~clk;
   end
   // Oscillator stand-in toggles each cycle; stopping it starves the monitor.
   always @(posedge clk) begin
      if (osc_run) osc <= ~osc;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a; wd <= d; wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask
   // Read data stands only in the cycle after the strobe.
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a; rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1 check(rdata, e);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic do_reset;
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
   endtask
   task automatic end_of_test;
      $display("mismatches %0d comparisons %0d", bad_count, comparisons);
      if (bad_count == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Watchdog on the whole run.
   initial begin
      #2000000;
      bad_count++;
      end_of_test();
   end
   initial begin
      do_reset();
      rd(`PLC_OFF_LOOP_CTL, `PLC_RESET_VAL);
      rd(`PLC_OFF_STATUS, 8'h02);
      rd(4'h5, 8'h00);
      wr(`PLC_OFF_LOOP_CTL, 8'h08);
      rd(`PLC_OFF_LOOP_CTL, 8'h00);
      check(pon, 1'b0);
      wr(`PLC_OFF_LOOP_CTL, 8'h01);
      rd(`PLC_OFF_LOOP_CTL, 8'h00);
      wr(`PLC_OFF_LOOP_CTL, 8'h56);
      rd(`PLC_OFF_LOOP_CTL, 8'h56);
      check({pon, hbw}, 2'b11);
      sel <= 1'b1;
      wr(`PLC_OFF_LOOP_CTL, 8'h06);
      rd(`PLC_OFF_LOOP_CTL, 8'h46);
      check(hbw, 1'b0);
      sel <= 1'b0; ow <= 1'b1; fe <= 8'h05;
      wr(`PLC_OFF_LOOP_CTL, 8'h46);
      rd(`PLC_OFF_LOOP_CTL, 8'h66);
      check(hbw, 1'b1);
      fe <= 8'h04;
      cyc(3);
      check(hbw, 1'b0);
      ow <= 1'b0;
      wr(`PLC_OFF_LOOP_CTL, 8'hc6);
      rd(`PLC_OFF_LOOP_CTL, 8'hc6);
      osc_run <= 1'b0;
      cyc(LOSS + 10);
      check({cmr, limp}, 2'b10);
      osc_run <= 1'b1;
      do_reset();
      osc_run <= 1'b0;
      cyc(LOSS + 10);
      check({limp, pon, cmr}, 3'b110);
      wr(`PLC_OFF_LOOP_CTL, 8'h00);
      rd(`PLC_OFF_LOOP_CTL, 8'h81);
      check(pon, 1'b1);
      osc_run <= 1'b1;
      cyc(6);
      lx <= 1'b1;
      cyc(2);
      lx <= 1'b0;
      cyc(2);
      check({limp, pon}, 2'b00);
      wr(`PLC_OFF_LOOP_CTL, 8'h00);
      rd(`PLC_OFF_LOOP_CTL, 8'h01);
      spec <= 1'b1;
      wr(`PLC_OFF_LOOP_CTL, 8'h80);
      rd(`PLC_OFF_LOOP_CTL, 8'h80);
      wr(`PLC_OFF_LOOP_CTL, 8'h83);
      rd(`PLC_OFF_LOOP_CTL, 8'h83);
      wr(`PLC_OFF_LOOP_CTL, 8'h82);
      stp <= 1'b1; osc_run <= 1'b0;
      cyc(LOSS + 10);
      check({limp, cmr, osce}, 3'b000);
      // Take the tick count in full stop: pseudo-stop must keep it intact.
      t0 = tick[7:0];
      osc_run <= 1'b1; ris <= 1'b1;
      cyc(3);
      check(osce, 1'b1);
      w0 = wdog;
      cyc(5);
      check(tick[7:0], t0);
      check(wdog !== w0, 1'b1);
      wr(`PLC_OFF_LOOP_CTL, 8'h84);
      cyc(2);
      w0 = wdog;
      cyc(5);
      check(wdog, w0);
      check(tick[7:0] !== t0, 1'b1);
      stp <= 1'b0; wt <= 1'b1; tsw <= 1'b1; wsw <= 1'b1;
      cyc(3);
      check(tick, 16'h0000);
      check(wdog, 16'h0000);
      wt <= 1'b0;
      cyc(2);
      end_of_test();
   end
endmodule
